// [include/ccr_map.svh]
// register offsets, field positions and reset values of the calibration bank
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ============================================================
// register indices (byte address is four times the index)
`define CCR_IDX_CTRL_TWO   8'h61
`define CCR_IDX_RING_GAIN  8'h62
`define CCR_IDX_TIP_GAIN   8'h63
`define CCR_IDX_DIFF_GAIN  8'h64
`define CCR_IDX_COMM_GAIN  8'h65
`define CCR_IDX_CUR_LIMIT  8'h66
`define CCR_IDX_MON_OFFSET 8'h67
`define CCR_IDX_ANA_POLAR  8'h68
`define CCR_IDX_DAC_OFFSET 8'h69
`define CCR_IDX_PEAK_CUR   8'h6b

// ============================================================
// reset values
`define CCR_RST_CTRL_TWO   8'h1f
`define CCR_RST_RING_GAIN  8'h10
`define CCR_RST_TIP_GAIN   8'h10
`define CCR_RST_DIFF_GAIN  8'h11
`define CCR_RST_COMM_GAIN  8'h11
`define CCR_RST_CUR_LIMIT  8'h08
`define CCR_RST_MON_OFFSET 8'h88
`define CCR_RST_ANA_POLAR  8'h00
`define CCR_RST_DAC_OFFSET 8'h00
`define CCR_RST_PEAK_CUR   8'h08

// ============================================================
// field positions
`define CCR_CAL_COUNT      5
`define CCR_GAIN_MSB       4
`define CCR_NIB_MSB        3
`define CCR_MON_ONE_LSB    4
`define CCR_POL_DAC_LSB    2
`define CCR_MIN_ADDR_W     10

`endif

// [include/ccr_pkg.sv]
// types shared by the calibration control and result bank
`default_nettype none

package ccr_pkg;

  // ============================================================
  // bit position of each calibration go bit in the control register
  typedef enum logic [2:0]
  {
    ccr_cal_balance = 3'h0,  // longitudinal balance
    ccr_cal_adc     = 3'h1,  // audio adc offset
    ccr_cal_dac     = 3'h2,  // audio dac offset
    ccr_cal_mon_two = 3'h3,  // second monitor adc
    ccr_cal_mon_one = 3'h4   // first monitor adc
  } ccr_cal_e;

  typedef logic [7:0] ccr_byte_t;  // one register of the bank

endpackage

`default_nettype wire

// [rtl/ccr_bank.sv]
// calibration control and result register bank behind an avalon-mm slave
//
// Operation
// - bit 4 runs first monitor adc calibration
// - bit 3 runs second monitor adc calibration
// - writing bit 2 starts audio dac offset
// - writing bit 1 starts audio adc offset
// - writing bit 0 starts longitudinal balance calibration
// - go bit reads one until calibration done
// - ring mismatch result, five bits read/write
// - tip mismatch result, five bits read/write
// - differential gain result, five bits read/write
// - common mode gain result, five bits
// - current limit result, four bits read/write
// - monitor offsets: one high nibble, two low
// - polarity bits: dac pos/neg, adc pos/neg
// - audio dac offset result, full byte
// - peak current monitor result, four bits
`include "ccr_map.svh"
`default_nettype none

module ccr_bank #(
  parameter int ADDR_W = 10  // byte address width of the slave
) (
  input  wire logic              i_clk,             // 20 mhz clock
  input  wire logic              i_rst,             // synchronous reset, active high
  input  wire logic [ADDR_W-1:0] i_avs_address,     // byte address
  input  wire logic              i_avs_read,        // read request
  input  wire logic              i_avs_write,       // write request
  input  wire logic [31:0]       i_avs_writedata,   // write data
  input  wire logic [3:0]        i_avs_byteenable,  // byte lanes, lane 0 carries data
  output logic [31:0]            o_avs_readdata,    // registered read data
  output logic                   o_avs_waitrequest, // stall request
  output logic [4:0]             o_cal_go,          // calibration enable levels
  input  wire logic [4:0]        i_cal_done,        // one-cycle done pulses from engines
  input  wire logic [3:0]        i_mon_one_result,  // first monitor offset outcome
  input  wire logic [3:0]        i_mon_two_result,  // second monitor offset outcome
  input  wire logic [7:0]        i_dac_result,      // audio dac offset outcome
  input  wire logic [1:0]        i_dac_polarity,    // dac offset polarity outcome
  input  wire logic [1:0]        i_adc_polarity     // adc offset polarity outcome
);

  // ============================================================
  // elaboration checks
  if (ADDR_W < `CCR_MIN_ADDR_W)
  begin : g_bad_addr
    $error("address too narrow for the bank");
  end

  // ============================================================
  // decode helpers
  // a register hit is an exact index match on the word address
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
    hit = (idx == target);
  endfunction

  logic [7:0]  word_idx;    // word index of the request
  logic        upper_zero;  // address bits above the bank are clear
  logic        wr_en;       // a write that lands in lane 0
  logic        rd_ack;      // read answer stands this cycle
  ccr_pkg::ccr_byte_t next_read;  // read mux output

  assign word_idx   = i_avs_address[9:2];
  assign upper_zero = ((i_avs_address >> 10) == '0);
  // writes need lane 0; upper lanes hold only reserved bits
  assign wr_en      = i_avs_write & i_avs_byteenable[0] & upper_zero;

  // ============================================================
  // register storage
  logic [4:0] go;         // calibration go bits
  logic [4:0] ring_mismatch_value;
  logic [4:0] tip_mismatch_value;
  logic [4:0] diff_gain_value;
  logic [4:0] common_gain_value;
  logic [3:0] current_limit_value;
  logic [3:0] monitor_offset_one_value;
  logic [3:0] monitor_offset_two_value;
  logic [3:0] polarity;   // dac pos, dac neg, adc pos, adc neg
  logic [7:0] audio_dac_offset_value;
  logic [3:0] peak_current_monitor_value;

  logic [4:0] go_set;     // software start per bit
  logic [4:0] go_done;    // engine finish while running

  // ============================================================
  // calibration go bits, one flop each
  // a start written in the cycle of a done keeps the bit set,
  // so a fresh request is never lost behind the old completion
  for (genvar g = 0; g < `CCR_CAL_COUNT; g++)
  begin : g_go
    localparam logic [7:0] RST_V = `CCR_RST_CTRL_TWO;
    assign go_set[g]  = wr_en & hit(word_idx, `CCR_IDX_CTRL_TWO) & i_avs_writedata[g];
    assign go_done[g] = go[g] & i_cal_done[g];

    always_ff @(posedge i_clk)
    begin
      if (i_rst)
        go[g] <= RST_V[g];
      else if (go_set[g])       // start
        go[g] <= 1'b1;
      else if (go_done[g])      // finished, back to normal
        go[g] <= 1'b0;
    end
  end

  // engines see the go levels directly
  assign o_cal_go = go;

  // ============================================================
  // plain read/write results from the first control register's
  // calibrations; their engines are outside this bank
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ring_mismatch_value <= 5'(`CCR_RST_RING_GAIN);
      tip_mismatch_value  <= 5'(`CCR_RST_TIP_GAIN);
      diff_gain_value     <= 5'(`CCR_RST_DIFF_GAIN);
      common_gain_value   <= 5'(`CCR_RST_COMM_GAIN);
      current_limit_value <= 4'(`CCR_RST_CUR_LIMIT);
      peak_current_monitor_value <= 4'(`CCR_RST_PEAK_CUR);
    end
    else if (wr_en)
    begin
      // only the documented field is stored; upper bits dropped
      if (hit(word_idx, `CCR_IDX_RING_GAIN))
        ring_mismatch_value <= i_avs_writedata[`CCR_GAIN_MSB:0];
      if (hit(word_idx, `CCR_IDX_TIP_GAIN))
        tip_mismatch_value <= i_avs_writedata[`CCR_GAIN_MSB:0];
      if (hit(word_idx, `CCR_IDX_DIFF_GAIN))
        diff_gain_value <= i_avs_writedata[`CCR_GAIN_MSB:0];
      if (hit(word_idx, `CCR_IDX_COMM_GAIN))
        common_gain_value <= i_avs_writedata[`CCR_GAIN_MSB:0];
      if (hit(word_idx, `CCR_IDX_CUR_LIMIT))
        current_limit_value <= i_avs_writedata[`CCR_NIB_MSB:0];
      if (hit(word_idx, `CCR_IDX_PEAK_CUR))
        peak_current_monitor_value <= i_avs_writedata[`CCR_NIB_MSB:0];
    end
  end

  // ============================================================
  // monitor adc offsets, loaded by software or by the engines
  // an engine outcome beats a software write in the same cycle,
  // since the outcome is the fresher measurement
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      monitor_offset_one_value <= 4'(`CCR_RST_MON_OFFSET >> `CCR_MON_ONE_LSB);
      monitor_offset_two_value <= 4'(`CCR_RST_MON_OFFSET);
    end
    else
    begin
      if (go_done[ccr_pkg::ccr_cal_mon_one])   // loaded on the clearing edge
        monitor_offset_one_value <= i_mon_one_result;
      else if (wr_en && hit(word_idx, `CCR_IDX_MON_OFFSET))
        monitor_offset_one_value <= i_avs_writedata[7:4];
      if (go_done[ccr_pkg::ccr_cal_mon_two])
        monitor_offset_two_value <= i_mon_two_result;
      else if (wr_en && hit(word_idx, `CCR_IDX_MON_OFFSET))
        monitor_offset_two_value <= i_avs_writedata[3:0];
    end
  end

  // ============================================================
  // analog offset polarity bits
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      polarity <= 4'(`CCR_RST_ANA_POLAR);
    else
    begin
      if (go_done[ccr_pkg::ccr_cal_dac])
        polarity[3:2] <= i_dac_polarity;
      else if (wr_en && hit(word_idx, `CCR_IDX_ANA_POLAR))
        polarity[3:2] <= i_avs_writedata[3:2];
      if (go_done[ccr_pkg::ccr_cal_adc])
        polarity[1:0] <= i_adc_polarity;
      else if (wr_en && hit(word_idx, `CCR_IDX_ANA_POLAR))
        polarity[1:0] <= i_avs_writedata[1:0];
    end
  end

  // ============================================================
  // audio dac offset result
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      audio_dac_offset_value <= `CCR_RST_DAC_OFFSET;
    else if (go_done[ccr_pkg::ccr_cal_dac])
      audio_dac_offset_value <= i_dac_result;
    else if (wr_en && hit(word_idx, `CCR_IDX_DAC_OFFSET))
      audio_dac_offset_value <= i_avs_writedata[7:0];
  end

  // ============================================================
  // read mux, reserved bits padded with zero
  always_comb
  begin
    next_read = '0;
    if (upper_zero)
    begin
      case (word_idx)
        `CCR_IDX_CTRL_TWO:   next_read = {3'h0, go};
        `CCR_IDX_RING_GAIN:  next_read = {3'h0, ring_mismatch_value};
        `CCR_IDX_TIP_GAIN:   next_read = {3'h0, tip_mismatch_value};
        `CCR_IDX_DIFF_GAIN:  next_read = {3'h0, diff_gain_value};
        `CCR_IDX_COMM_GAIN:  next_read = {3'h0, common_gain_value};
        `CCR_IDX_CUR_LIMIT:  next_read = {4'h0, current_limit_value};
        `CCR_IDX_MON_OFFSET: next_read = {monitor_offset_one_value, monitor_offset_two_value};
        `CCR_IDX_ANA_POLAR:  next_read = {4'h0, polarity};
        `CCR_IDX_DAC_OFFSET: next_read = audio_dac_offset_value;
        `CCR_IDX_PEAK_CUR:   next_read = {4'h0, peak_current_monitor_value};
        default:             next_read = '0;  // unmapped reads zero
      endcase
    end
  end

  // ============================================================
  // read handshake: one wait cycle, then data from a flop
  // writes never wait; reads cost one stall so data is registered
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rd_ack <= 1'b0;
    else
      rd_ack <= i_avs_read & ~rd_ack;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_avs_readdata <= '0;
    else if (i_avs_read && !rd_ack)
      o_avs_readdata <= {24'h0, next_read};   // upper lanes reserved
  end

  assign o_avs_waitrequest = i_avs_read & ~rd_ack;

  // ============================================================
  // assertions
  default clocking ccr_cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence ctrl_write_s(int b);
    wr_en && hit(word_idx, `CCR_IDX_CTRL_TWO) && i_avs_writedata[b];
  endsequence

  sequence run_done_s(int b);
    go[b] && i_cal_done[b] && !go_set[b];
  endsequence

  mon_one_start_a: assert property (ctrl_write_s(4) |=> go[4])
    else $error("monitor one go bit did not set");
  mon_two_start_a: assert property (ctrl_write_s(3) |=> go[3])
    else $error("monitor two go bit did not set");
  dac_start_a: assert property (ctrl_write_s(2) |=> o_cal_go[2])
    else $error("dac offset calibration did not start");
  adc_start_a: assert property (ctrl_write_s(1) |=> o_cal_go[1])
    else $error("adc offset calibration did not start");
  balance_start_a: assert property (ctrl_write_s(0) |=> o_cal_go[0])
    else $error("balance calibration did not start");
  go_clear_a: assert property (run_done_s(2) |=> !go[2] && !o_cal_go[2])
    else $error("go bit did not clear on done");
  go_hold_a: assert property (go[0] && !i_cal_done[0] |=> go[0])
    else $error("go bit dropped without done");

  ring_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_RING_GAIN)
    |=> ring_mismatch_value == $past(i_avs_writedata[4:0]))
    else $error("ring mismatch field not written");
  tip_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_TIP_GAIN)
    |=> tip_mismatch_value == $past(i_avs_writedata[4:0]))
    else $error("tip mismatch field not written");
  diff_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_DIFF_GAIN)
    |=> diff_gain_value == $past(i_avs_writedata[4:0]))
    else $error("differential gain field not written");
  comm_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_COMM_GAIN)
    |=> common_gain_value == $past(i_avs_writedata[4:0]))
    else $error("common gain field not written");
  ilim_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_CUR_LIMIT)
    |=> current_limit_value == $past(i_avs_writedata[3:0]))
    else $error("current limit field not written");
  mon_load_a: assert property (go_done[4]
    |=> monitor_offset_one_value == $past(i_mon_one_result) && (!go[4] || $past(go_set[4])))
    else $error("monitor one result not loaded");
  polar_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_ANA_POLAR) && !go_done[2] && !go_done[1]
    |=> polarity == $past(i_avs_writedata[3:0]))
    else $error("polarity bits not written");
  dac_load_a: assert property (go_done[2]
    |=> audio_dac_offset_value == $past(i_dac_result) && polarity[3:2] == $past(i_dac_polarity))
    else $error("dac offset result not loaded");
  peak_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_PEAK_CUR)
    |=> peak_current_monitor_value == $past(i_avs_writedata[3:0]))
    else $error("peak current field not written");
  reserved_zero_a: assert property (rd_ack && $past(word_idx) == `CCR_IDX_CTRL_TWO
    |-> o_avs_readdata[31:5] == '0 && o_avs_readdata[4:0] == $past(go))
    else $error("control readback wrong or reserved bits set");
  read_answer_a: assert property (i_avs_read && !rd_ack |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("read not answered after one wait cycle");
  adc_load_a: assert property (go_done[1] |=> polarity[1:0] == $past(i_adc_polarity))
    else $error("adc polarity not loaded with done");

  // ============================================================
  // idle pulses and the remaining go bits
  // an engine may pulse done while its go bit is already low,
  // for instance after its calibration has finished; nothing may move then
  // software is kept out so a write cannot pass for a stray load
  sequence idle_done_s(int b);
    !go[b] && i_cal_done[b] && !wr_en;
  endsequence

  idle_mon_a: assert property (idle_done_s(4) |=> !go[4] && $stable(monitor_offset_one_value))
    else $error("idle monitor done changed state");
  idle_dac_a: assert property (idle_done_s(2) |=> !go[2] && $stable(audio_dac_offset_value))
    else $error("idle dac done changed state");
  mon_clear_a: assert property (run_done_s(3) |=> !go[3])
    else $error("monitor two go bit did not clear");
  balance_clear_a: assert property (run_done_s(0) |=> !o_cal_go[0])
    else $error("balance go bit did not clear");
  mon_two_load_a: assert property (go_done[3] |=> monitor_offset_two_value == $past(i_mon_two_result))
    else $error("monitor two result not loaded");
  set_wins_a: assert property (go_set[2] && go_done[2]
    |=> go[2] && audio_dac_offset_value == $past(i_dac_result))
    else $error("restart lost or result dropped");

  // ============================================================
  // software writes into fields that engines also load
  // a same-cycle engine outcome wins, so those cycles are left out
  mon_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_MON_OFFSET) && !go_done[4] && !go_done[3]
    |=> {monitor_offset_one_value, monitor_offset_two_value} == $past(i_avs_writedata[7:0]))
    else $error("monitor offset fields not written");
  dac_write_a: assert property (wr_en && hit(word_idx, `CCR_IDX_DAC_OFFSET) && !go_done[2]
    |=> audio_dac_offset_value == $past(i_avs_writedata[7:0]))
    else $error("dac offset field not written");
  lane_off_a: assert property (i_avs_write && !i_avs_byteenable[0] && !go_done[2]
    |=> $stable(ring_mismatch_value) && $stable(audio_dac_offset_value))
    else $error("write without lane 0 changed a field");

  // ============================================================
  // readback: reserved bits, gaps in the map, how long data stands
  // data is latched on the same edge that raises rd_ack, hence the past values
  upper_lanes_a: assert property (rd_ack |-> o_avs_readdata[31:8] == '0)
    else $error("reserved upper lanes read nonzero");
  ring_readback_a: assert property (rd_ack && $past(word_idx) == `CCR_IDX_RING_GAIN
    |-> o_avs_readdata[7:0] == {3'h0, $past(ring_mismatch_value)})
    else $error("ring mismatch readback wrong");
  tip_readback_a: assert property (rd_ack && $past(word_idx) == `CCR_IDX_TIP_GAIN
    |-> o_avs_readdata[7:0] == {3'h0, $past(tip_mismatch_value)})
    else $error("tip mismatch readback wrong");
  ilim_readback_a: assert property (rd_ack && $past(word_idx) == `CCR_IDX_CUR_LIMIT
    |-> o_avs_readdata[7:0] == {4'h0, $past(current_limit_value)})
    else $error("current limit readback wrong");
  peak_readback_a: assert property (rd_ack && $past(word_idx) == `CCR_IDX_PEAK_CUR
    |-> o_avs_readdata[7:0] == {4'h0, $past(peak_current_monitor_value)})
    else $error("peak current readback wrong");
  polar_readback_a: assert property (rd_ack && $past(word_idx) == `CCR_IDX_ANA_POLAR
    |-> o_avs_readdata[7:0] == {4'h0, $past(polarity)})
    else $error("polarity readback wrong");
  gap_zero_a: assert property (rd_ack && $past(word_idx) < `CCR_IDX_CTRL_TWO
    |-> o_avs_readdata == '0)
    else $error("unmapped address read nonzero");
  data_stands_a: assert property (!(i_avs_read && !rd_ack) |=> $stable(o_avs_readdata))
    else $error("read data changed outside a read");
  write_nowait_a: assert property (i_avs_write |-> !o_avs_waitrequest)
    else $error("write was stalled");

endmodule

`default_nettype wire

// [testbench/ccr_bank_bench.sv]
// self-checking bench for the calibration control and result bank
`default_nettype none

module ccr_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // stimulus and observed signals
  logic        i_clk = 1'b0;            // 20 mhz clock
  logic        i_rst = 1'b1;            // reset, held at start
  logic [9:0]  i_avs_address = 10'h000; // byte address
  logic        i_avs_read = 1'b0;       // read strobe
  logic        i_avs_write = 1'b0;      // write strobe
  logic [31:0] i_avs_writedata = '0;    // write data
  logic [3:0]  i_avs_byteenable = 4'h1; // byte lanes
  logic [31:0] o_avs_readdata;          // read data
  logic        o_avs_waitrequest;       // stall
  logic [4:0]  o_cal_go;                // go levels
  logic [4:0]  i_cal_done = 5'h00;      // done pulses
  logic [3:0]  i_mon_one_result = 4'h3; // engine outcomes
  logic [3:0]  i_mon_two_result = 4'h6;
  logic [7:0]  i_dac_result = 8'h9c;
  logic [1:0]  i_dac_polarity = 2'h2;
  logic [1:0]  i_adc_polarity = 2'h1;
  int          n_errors = 0;            // mismatches
  int          cmp_count = 0;           // comparisons

  // register row: index, reset value, writable mask
  typedef struct {logic [7:0] idx; logic [7:0] rstv; logic [7:0] mask;} ccr_row_s;
  // calibration row: go bit, result index, value after done
  typedef struct {int b; logic [7:0] idx; logic [7:0] val;} ccr_cal_s;
  ccr_row_s    rows [10] = '{'{8'h61, 8'h1f, 8'h1f}, '{8'h62, 8'h10, 8'h1f}, '{8'h63, 8'h10, 8'h1f},
                             '{8'h64, 8'h11, 8'h1f}, '{8'h65, 8'h11, 8'h1f}, '{8'h66, 8'h08, 8'h0f},
                             '{8'h67, 8'h88, 8'hff}, '{8'h68, 8'h00, 8'h0f}, '{8'h69, 8'h00, 8'hff},
                             '{8'h6b, 8'h08, 8'h0f}};
  ccr_cal_s    cals [5] = '{'{4, 8'h67, 8'h30}, '{3, 8'h67, 8'h36}, '{2, 8'h69, 8'h9c},
                            '{1, 8'h68, 8'h09}, '{0, 8'h61, 8'h00}};
  logic [7:0]  pats [3] = '{8'hff, 8'ha5, 8'h00}; // write patterns
  logic [4:0]  go_exp;                  // expected go levels

  // ============================================================
  // device under test
  ccr_bank #(.ADDR_W(10)) uut (
    .i_clk             (i_clk),
    .i_rst             (i_rst),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .o_cal_go          (o_cal_go),
    .i_cal_done        (i_cal_done),
    .i_mon_one_result  (i_mon_one_result),
    .i_mon_two_result  (i_mon_two_result),
    .i_dac_result      (i_dac_result),
    .i_dac_polarity    (i_dac_polarity),
    .i_adc_polarity    (i_adc_polarity)
  );

  // ============================================================
  // clock
  always #25 i_clk = ~i_clk;

  // ============================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // avalon write; the wait is decided mid-cycle so the edge never races
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    logic wt;
    @(posedge i_clk);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    i_avs_write <= 1'b1;
    do
    begin
      @(negedge i_clk);
      wt = o_avs_waitrequest;
      @(posedge i_clk);
    end while (wt !== 1'b0);
    i_avs_write <= 1'b0;
  endtask

  // avalon read and compare of the whole word
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    logic        wt;
    logic        first;
    logic [31:0] d;
    first = 1'b1;
    @(posedge i_clk);
    i_avs_address <= {idx, 2'b00};
    i_avs_read <= 1'b1;
    do
    begin
      @(negedge i_clk);
      wt = o_avs_waitrequest;
      d = o_avs_readdata;
      if (first)
        chk({31'h0, wt}, 32'h1);
      first = 1'b0;
      @(posedge i_clk);
    end while (wt !== 1'b0);
    i_avs_read <= 1'b0;
    chk(d, {24'h0, exp});
  endtask

  // one-cycle done pulse from an engine
  task automatic pulse(input int b);
    @(posedge i_clk);
    i_cal_done <= 5'h01 << b;
    @(posedge i_clk);
    i_cal_done <= 5'h00;
  endtask

  task automatic check_reset();
    @(negedge i_clk);
    chk({27'h0, o_cal_go}, 32'h1f);
    foreach (rows[i])
      rdchk(rows[i].idx, rows[i].rstv);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ============================================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    wrap_up();
  end

  // ============================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    check_reset();
    // table: every pattern into every register; go bits only set
    foreach (pats[p])
      foreach (rows[i])
      begin
        wr(rows[i].idx, pats[p], 4'h1);
        rdchk(rows[i].idx, (rows[i].idx == 8'h61) ? 8'h1f : (pats[p] & rows[i].mask));
      end
    // unmapped places and a write with lane 0 off
    wr(8'h6a, 8'hff, 4'h1);
    rdchk(8'h6a, 8'h00);
    rdchk(8'h60, 8'h00);
    wr(8'h62, 8'h0b, 4'he);
    rdchk(8'h62, 8'h00);
    // each engine finishes in turn; result lands as its go bit clears
    go_exp = 5'h1f;
    foreach (cals[i])
    begin
      pulse(cals[i].b);
      go_exp[cals[i].b] = 1'b0;
      @(negedge i_clk);
      chk({27'h0, o_cal_go}, {27'h0, go_exp});
      rdchk(cals[i].idx, cals[i].val);
      rdchk(8'h61, {3'h0, go_exp});
    end
    // stray done with no calibration running changes nothing
    i_mon_one_result <= 4'hf;
    pulse(4);
    rdchk(8'h67, 8'h36);
    i_dac_result <= 8'h55;
    pulse(2);
    rdchk(8'h69, 8'h9c);
    // restart the dac calibration; a zero write cannot abort it
    wr(8'h61, 8'h04, 4'h1);
    @(negedge i_clk);
    chk({27'h0, o_cal_go}, 32'h04);
    wr(8'h61, 8'h00, 4'h1);
    @(negedge i_clk);
    chk({27'h0, o_cal_go}, 32'h04);
    // set in the same cycle as done: go stays up, result still loads
    @(posedge i_clk);
    i_dac_result <= 8'h47;
    fork
      wr(8'h61, 8'h04, 4'h1);
      pulse(2);
    join
    @(negedge i_clk);
    chk({27'h0, o_cal_go}, 32'h04);
    rdchk(8'h69, 8'h47);
    pulse(2);
    @(negedge i_clk);
    chk({27'h0, o_cal_go}, 32'h00);
    // second reset with no calibration running restores every register
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    check_reset();
    wrap_up();
  end

endmodule

`default_nettype wire
